// ---- core/atm_cfg.svh ----
// Constants of the analog threshold monitor: offsets, reset values, timing.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef ATM_CFG_SVH
`define ATM_CFG_SVH

// =====================================================================
// Sample format
`define ATM_FULL_SCALE 12'hFFF

// =====================================================================
// Global register byte offsets
`define ATM_REG_STAT 8'h00
`define ATM_REG_MASK 8'h04
`define ATM_REG_LAST 8'h08

// =====================================================================
// Channel windows: channel n at base + n * stride, selected by adr[5]
`define ATM_CH_SEL 2'h1
`define ATM_OFS_CTRL 5'h00
`define ATM_OFS_LOW 5'h04
`define ATM_OFS_HIGH 5'h08
`define ATM_OFS_ACT_LO 5'h0C
`define ATM_OFS_ACT_OK 5'h10
`define ATM_OFS_ACT_HI 5'h14
`define ATM_OFS_DELAY 5'h18
`define ATM_OFS_VALUE 5'h1C

// =====================================================================
// Status bit positions (plus channel number)
`define ATM_ST_EVENT 3'h0
`define ATM_ST_ALM_LO 3'h2
`define ATM_ST_ALM_HI 3'h4

// =====================================================================
// Reset values
`define ATM_RST_HIGH 12'hFFF

// =====================================================================
// Timing: alarm delay counts in ticks of 1 ms
`define ATM_CLK_PERIOD_NS 4
`define ATM_TICK_NS 1000000
`define ATM_TICK_CYCLES (`ATM_TICK_NS / `ATM_CLK_PERIOD_NS)

`endif

// ---- core/atm_pkg.sv ----
// Types of the analog threshold monitor.
// Assumes atm_cfg.svh for the numeric constants.
package atm_pkg;

	typedef enum logic [1:0] {
		Z_NONE = 2'b00,
		Z_LOW = 2'b01,
		Z_OK = 2'b10,
		Z_HIGH = 2'b11
	} zone_t;

	typedef struct packed {
		logic admin;
		logic sup;
		logic ahi;
		logic alo;
		logic flip;
	} ctrl_t;

	typedef struct packed {
		ctrl_t ctrl;
		logic [11:0] lo;
		logic [11:0] hi;
		logic [2:0][15:0] act;
		logic [31:0] delay;
	} cfg_t;

	typedef struct packed {
		zone_t zone;
		logic [11:0] value;
		logic [31:0] dcnt;
		logic alm_lo;
		logic alm_hi;
	} chst_t;

	typedef struct packed {
		logic [11:0] d1;
		logic [11:0] d2;
		logic c1;
		logic c2;
		logic t1;
		logic t2;
		logic t3;
	} sync_t;

	typedef struct packed {
		cfg_t [1:0] cfg;
		chst_t [1:0] ch;
		sync_t sy;
		logic [31:0] tick_cnt;
		logic tick;
		logic [5:0] stat;
		logic [5:0] mask;
		logic ack;
		logic [31:0] rdat;
		logic ev_valid;
		logic [15:0] ev_code;
		logic ev_chan;
		logic irq;
	} state_t;

endpackage

// ---- core/analog_threshold_monitor.sv ----
// Two-channel analog threshold monitor with Wishbone register access.
// Assumes an external 12-bit converter that presents a sample, its channel
// and a toggle; data and channel are stable before the toggle changes.
//
// Notes on behaviour
// - Input span zero to supply maps to codes zero through full scale.
// - Each input arrives as a twelve-bit sample before any comparison.
// - Entering the below-low zone issues that channel's low action code.
// - Entering the band low..high, limits included, issues the in-range code.
// - Entering the above-high zone issues that channel's high action code.
// - Each channel holds its own programmable low and high limit.
// - Three action codes are stored; descriptive labels are not kept.
// - With scale flip set, full scale minus the sample is used.
// - Each channel has a programmable alarm delay in millisecond ticks.
// - Low alarm rises when enabled and value stays low past the delay.
// - High alarm rises when enabled and value stays high past the delay.
// - Event suppress blocks all action codes for that channel.
// - Scale flip changes only while the channel's admin flag is set.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "atm_cfg.svh"

module analog_threshold_monitor #(
	parameter int TICK_CYCLES = `ATM_TICK_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [11:0] i_adc_data,
	input wire logic i_adc_chan,
	input wire logic i_adc_tgl,
	output logic o_event_valid,
	output logic [15:0] o_event_code,
	output logic o_event_chan,
	output logic [1:0] o_alarm_lo,
	output logic [1:0] o_alarm_hi,
	output logic o_irq
);

	// =================================================================
	// State
	atm_pkg::state_t s;
	atm_pkg::state_t n;
	logic smp;
	logic smp_ch;
	logic [11:0] smp_val;
	atm_pkg::zone_t smp_zone;
	logic smp_chg;
	logic [1:0] zi;
	logic [31:0] wv;
	logic [4:0] ofs;
	logic wch;
	logic out_lo;
	logic out_hi;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return r;
	endfunction

	// =================================================================
	// Next state
	always_comb begin
		n = s;
		wv = 32'h0000_0000;
		ofs = i_wb_adr[4:0];
		wch = i_wb_adr[5];
		out_lo = 1'b0;
		out_hi = 1'b0;
		// Pins pass two flip-flops; the third only serves edge detection
		n.sy.d1 = i_adc_data;
		n.sy.d2 = s.sy.d1;
		n.sy.c1 = i_adc_chan;
		n.sy.c2 = s.sy.c1;
		n.sy.t1 = i_adc_tgl;
		n.sy.t2 = s.sy.t1;
		n.sy.t3 = s.sy.t2;
		smp = s.sy.t2 ^ s.sy.t3;
		smp_ch = s.sy.c2;
		if (s.cfg[smp_ch].ctrl.flip) begin
			smp_val = `ATM_FULL_SCALE - s.sy.d2;
		end else begin
			smp_val = s.sy.d2;
		end
		if (smp_val < s.cfg[smp_ch].lo) begin
			smp_zone = atm_pkg::Z_LOW;
		end else if (smp_val > s.cfg[smp_ch].hi) begin
			smp_zone = atm_pkg::Z_HIGH;
		end else begin
			smp_zone = atm_pkg::Z_OK;
		end
		smp_chg = smp && (smp_zone != s.ch[smp_ch].zone);
		zi = smp_zone - 2'h1;

		// Millisecond tick for alarm delays
		n.tick = 1'b0;
		if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
			n.tick_cnt = 32'h0000_0000;
			n.tick = 1'b1;
		end else begin
			n.tick_cnt = s.tick_cnt + 32'h0000_0001;
		end

		// Register bus: one wait state, ack for one cycle
		n.ack = 1'b0;
		if (i_wb_cyc && i_wb_stb && !s.ack) begin
			n.ack = 1'b1;
			n.rdat = 32'h0000_0000;
			if (i_wb_adr[7:6] == `ATM_CH_SEL) begin
				unique case (ofs)
				`ATM_OFS_CTRL: n.rdat = {27'h0, s.cfg[wch].ctrl};
				`ATM_OFS_LOW: n.rdat = {20'h0, s.cfg[wch].lo};
				`ATM_OFS_HIGH: n.rdat = {20'h0, s.cfg[wch].hi};
				`ATM_OFS_ACT_LO: n.rdat = {16'h0, s.cfg[wch].act[0]};
				`ATM_OFS_ACT_OK: n.rdat = {16'h0, s.cfg[wch].act[1]};
				`ATM_OFS_ACT_HI: n.rdat = {16'h0, s.cfg[wch].act[2]};
				`ATM_OFS_DELAY: n.rdat = s.cfg[wch].delay;
				`ATM_OFS_VALUE: n.rdat = {12'h0, s.ch[wch].alm_hi,
					s.ch[wch].alm_lo, s.ch[wch].zone, 4'h0,
					s.ch[wch].value};
				default: n.rdat = 32'h0000_0000;
				endcase
				if (i_wb_we) begin
					unique case (ofs)
					`ATM_OFS_CTRL: begin
						wv = merge({27'h0, s.cfg[wch].ctrl}, i_wb_dat,
							i_wb_sel);
						n.cfg[wch].ctrl = atm_pkg::ctrl_t'(wv[4:0]);
						if (!s.cfg[wch].ctrl.admin) begin
							n.cfg[wch].ctrl.flip = s.cfg[wch].ctrl.flip;
						end
					end
					`ATM_OFS_LOW: begin
						wv = merge({20'h0, s.cfg[wch].lo}, i_wb_dat, i_wb_sel);
						n.cfg[wch].lo = wv[11:0];
					end
					`ATM_OFS_HIGH: begin
						wv = merge({20'h0, s.cfg[wch].hi}, i_wb_dat, i_wb_sel);
						n.cfg[wch].hi = wv[11:0];
					end
					`ATM_OFS_ACT_LO: begin
						wv = merge({16'h0, s.cfg[wch].act[0]}, i_wb_dat,
							i_wb_sel);
						n.cfg[wch].act[0] = wv[15:0];
					end
					`ATM_OFS_ACT_OK: begin
						wv = merge({16'h0, s.cfg[wch].act[1]}, i_wb_dat,
							i_wb_sel);
						n.cfg[wch].act[1] = wv[15:0];
					end
					`ATM_OFS_ACT_HI: begin
						wv = merge({16'h0, s.cfg[wch].act[2]}, i_wb_dat,
							i_wb_sel);
						n.cfg[wch].act[2] = wv[15:0];
					end
					`ATM_OFS_DELAY: begin
						n.cfg[wch].delay = merge(s.cfg[wch].delay, i_wb_dat,
							i_wb_sel);
					end
					default: begin
					end
					endcase
				end
			end else begin
				unique case (i_wb_adr)
				`ATM_REG_STAT: n.rdat = {26'h0, s.stat};
				`ATM_REG_MASK: n.rdat = {26'h0, s.mask};
				`ATM_REG_LAST: n.rdat = {15'h0, s.ev_chan, s.ev_code};
				default: n.rdat = 32'h0000_0000;
				endcase
				if (i_wb_we && i_wb_sel[0]) begin
					if (i_wb_adr == `ATM_REG_STAT) begin
						n.stat = s.stat & ~i_wb_dat[5:0];
					end else if (i_wb_adr == `ATM_REG_MASK) begin
						n.mask = i_wb_dat[5:0];
					end
				end
			end
		end

		// Zone tracking and action codes; sets below win over a clear
		n.ev_valid = 1'b0;
		if (smp) begin
			n.ch[smp_ch].value = smp_val;
			n.ch[smp_ch].zone = smp_zone;
		end
		if (smp_chg) begin
			n.ch[smp_ch].dcnt = 32'h0000_0000;
			n.ch[smp_ch].alm_lo = 1'b0;
			n.ch[smp_ch].alm_hi = 1'b0;
			if (!s.cfg[smp_ch].ctrl.sup) begin
				n.ev_valid = 1'b1;
				n.ev_code = s.cfg[smp_ch].act[zi];
				n.ev_chan = smp_ch;
				n.stat[`ATM_ST_EVENT + {2'h0, smp_ch}] = 1'b1;
			end
		end

		// Delayed alarms per channel
		for (int c = 0; c < 2; c++) begin
			out_lo = (n.ch[c].zone == atm_pkg::Z_LOW) && s.cfg[c].ctrl.alo;
			out_hi = (n.ch[c].zone == atm_pkg::Z_HIGH) && s.cfg[c].ctrl.ahi;
			if (!(out_lo || out_hi)) begin
				n.ch[c].dcnt = 32'h0000_0000;
				n.ch[c].alm_lo = 1'b0;
				n.ch[c].alm_hi = 1'b0;
			end else if (!(smp_chg && (smp_ch == c[0]))) begin
				if (s.ch[c].dcnt >= s.cfg[c].delay) begin
					if (out_lo && !s.ch[c].alm_lo) begin
						n.ch[c].alm_lo = 1'b1;
						n.stat[`ATM_ST_ALM_LO + 3'(c)] = 1'b1;
					end
					if (out_hi && !s.ch[c].alm_hi) begin
						n.ch[c].alm_hi = 1'b1;
						n.stat[`ATM_ST_ALM_HI + 3'(c)] = 1'b1;
					end
				end else if (s.tick) begin
					n.ch[c].dcnt = s.ch[c].dcnt + 32'h0000_0001;
				end
			end
		end
		n.irq = |(n.stat & n.mask);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			s <= '0;
			s.cfg[0].hi <= `ATM_RST_HIGH;
			s.cfg[1].hi <= `ATM_RST_HIGH;
		end else begin
			s <= n;
		end
	end

	// =================================================================
	// Outputs
	assign o_wb_dat = s.rdat;
	assign o_wb_ack = s.ack;
	assign o_event_valid = s.ev_valid;
	assign o_event_code = s.ev_code;
	assign o_event_chan = s.ev_chan;
	assign o_alarm_lo = {s.ch[1].alm_lo, s.ch[0].alm_lo};
	assign o_alarm_hi = {s.ch[1].alm_hi, s.ch[0].alm_hi};
	assign o_irq = s.irq;

	// =================================================================
	// Assertions
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	logic ctrl_wr0;
	assign ctrl_wr0 = i_wb_cyc && i_wb_stb && i_wb_we && !s.ack
		&& (i_wb_adr == 8'h40) && i_wb_sel[0];

	property p_raw_value;
		smp && !smp_ch && !s.cfg[0].ctrl.flip
			|=> s.ch[0].value == $past(s.sy.d2);
	endproperty
	a_raw_value: assert property (p_raw_value)
		else $error("raw sample not stored");

	property p_flip_value;
		smp && !smp_ch && s.cfg[0].ctrl.flip
			|=> s.ch[0].value + $past(s.sy.d2) == 12'hFFF;
	endproperty
	a_flip_value: assert property (p_flip_value)
		else $error("flipped sample wrong");

	property p_low_code;
		smp_chg && !s.cfg[smp_ch].ctrl.sup && smp_zone == atm_pkg::Z_LOW
			|=> o_event_valid && o_event_code == $past(s.cfg[smp_ch].act[0]);
	endproperty
	a_low_code: assert property (p_low_code)
		else $error("low action code missing");

	property p_ok_code;
		smp_chg && !s.cfg[smp_ch].ctrl.sup && smp_zone == atm_pkg::Z_OK
			|=> o_event_valid && o_event_code == $past(s.cfg[smp_ch].act[1]);
	endproperty
	a_ok_code: assert property (p_ok_code)
		else $error("in-range action code missing");

	property p_high_code;
		smp_chg && !s.cfg[smp_ch].ctrl.sup && smp_zone == atm_pkg::Z_HIGH
			|=> o_event_valid && o_event_code == $past(s.cfg[smp_ch].act[2]);
	endproperty
	a_high_code: assert property (p_high_code)
		else $error("high action code missing");

	property p_suppress;
		smp && s.cfg[smp_ch].ctrl.sup |=> !o_event_valid;
	endproperty
	a_suppress: assert property (p_suppress)
		else $error("event issued while suppressed");

	property p_once;
		o_event_valid |-> $past(smp_chg);
	endproperty
	a_once: assert property (p_once)
		else $error("event without zone change");

	property p_flip_locked;
		ctrl_wr0 && !s.cfg[0].ctrl.admin |=> $stable(s.cfg[0].ctrl.flip);
	endproperty
	a_flip_locked: assert property (p_flip_locked)
		else $error("flip changed without admin");

	property p_alarm_lo;
		$rose(o_alarm_lo[0]) |-> s.ch[0].zone == atm_pkg::Z_LOW
			&& s.cfg[0].ctrl.alo && $past(s.ch[0].dcnt) >= s.cfg[0].delay;
	endproperty
	a_alarm_lo: assert property (p_alarm_lo)
		else $error("low alarm without cause");

	property p_alarm_hi;
		$rose(o_alarm_hi[0]) |-> s.ch[0].zone == atm_pkg::Z_HIGH
			&& s.cfg[0].ctrl.ahi && $past(s.ch[0].dcnt) >= s.cfg[0].delay;
	endproperty
	a_alarm_hi: assert property (p_alarm_hi)
		else $error("high alarm without cause");

	property p_cancel;
		s.ch[0].zone == atm_pkg::Z_OK |-> !o_alarm_lo[0] && !o_alarm_hi[0];
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("alarm held while in range");

	c_event: cover property (smp_chg ##1 o_event_valid);
	c_alm_lo: cover property ($rose(o_alarm_lo[0]));
	c_alm_hi: cover property ($rose(o_alarm_hi[0]));
	c_irq: cover property ($rose(o_irq));

endmodule

`default_nettype wire

// ---- test/atm_sensor_model.sv ----
// Behavioural converter front end that feeds the monitor's sample port.
// Assumes one request pulse from the bench per sample, on the system clock.
`timescale 1ns/1ns
`default_nettype none
module atm_sensor_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_req,
	input wire logic [11:0] i_level,
	input wire logic i_chan,
	output logic [11:0] o_adc_data,
	output logic o_adc_chan,
	output logic o_adc_tgl,
	output logic o_busy
);
	logic [3:0] cnt;
	always @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			cnt <= 4'h0;
			o_busy <= 1'b0;
			o_adc_tgl <= 1'b0;
			o_adc_data <= 12'h000;
			o_adc_chan <= 1'b0;
		end else if (!o_busy && i_req) begin
			// Twelve-bit code: 000 at ground up to FFF at supply
			o_adc_data <= i_level;
			o_adc_chan <= i_chan;
			o_busy <= 1'b1;
			cnt <= 4'h1;
		end else if (o_busy) begin
			cnt <= cnt + 4'h1;
			// Data settles four clocks before the toggle, holds seven after
			if (cnt == 4'h4)
				o_adc_tgl <= ~o_adc_tgl;
			if (cnt == 4'hB)
				o_busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- test/tb_analog_threshold_monitor.sv ----
// Self-checking bench for the analog threshold monitor.
// Assumes the sensor model drives the sample port; Wishbone from tasks here.
`timescale 1ns/1ns
`default_nettype none
`include "atm_cfg.svh"
module tb_analog_threshold_monitor;
	logic i_sys_clk, i_rst_b, cyc, stb, we, ack, req, chan, busy;
	logic adc_chan, adc_tgl, ev_valid, ev_chan, irq;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	logic [11:0] level, adc_data;
	logic [15:0] ev_code;
	logic [1:0] alm_lo, alm_hi;
	int err_count, comparisons, ev_count, n;

	always #2 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk)
		if (ev_valid === 1'b1)
			ev_count <= ev_count + 1;

	analog_threshold_monitor #(.TICK_CYCLES(4)) DUT (.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_adc_data(adc_data), .i_adc_chan(adc_chan),
		.i_adc_tgl(adc_tgl), .o_event_valid(ev_valid),
		.o_event_code(ev_code), .o_event_chan(ev_chan),
		.o_alarm_lo(alm_lo), .o_alarm_hi(alm_hi), .o_irq(irq));
	atm_sensor_model sensor (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_req(req), .i_level(level), .i_chan(chan), .o_adc_data(adc_data),
		.o_adc_chan(adc_chan), .o_adc_tgl(adc_tgl), .o_busy(busy));

	// ==================================================================
	// Access tasks
	function automatic logic [7:0] ca(input logic c, input logic [4:0] o);
		return {2'b01, c, o};
	endfunction
	function automatic logic [31:0] vr(input logic [1:0] z,
		input logic [11:0] v);
		return {14'h0000, z, 4'h0, v};
	endfunction
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_sys_clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic smp(input logic c, input logic [11:0] v);
		@(posedge i_sys_clk);
		req <= 1'b1;
		level <= v;
		chan <= c;
		@(posedge i_sys_clk);
		req <= 1'b0;
		@(posedge i_sys_clk);
		while (busy !== 1'b0) begin
			@(posedge i_sys_clk);
		end
		repeat (2) @(posedge i_sys_clk);
	endtask
	task results;
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		err_count++;
		results;
	end

	// ==================================================================
	// Test sequence
	initial begin
		{i_sys_clk, i_rst_b, cyc, stb, we, req, chan} = 7'h00;
		{adr, level, wdat, sel} = {8'h00, 12'h000, 32'h0, 4'hF};
		{err_count, comparisons, ev_count} = {32'h0, 32'h0, 32'h0};
		repeat (12) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		rdchk(ca(0, `ATM_OFS_HIGH), {20'h0, `ATM_RST_HIGH});
		rdchk(ca(0, `ATM_OFS_LOW), 32'h0);
		wb(1, ca(0, `ATM_OFS_LOW), 32'h100);
		wb(1, ca(0, `ATM_OFS_HIGH), 32'h800);
		wb(1, ca(0, `ATM_OFS_ACT_LO), 32'hA001);
		wb(1, ca(0, `ATM_OFS_ACT_OK), 32'hA002);
		wb(1, ca(0, `ATM_OFS_ACT_HI), 32'hA003);
		wb(1, `ATM_REG_MASK, 32'h1);
		smp(0, 12'h050);
		chk({16'h0, ev_code}, 32'hA001);
		rdchk(ca(0, `ATM_OFS_VALUE), vr(2'h1, 12'h050));
		chk({31'h0, irq}, 32'h1);
		wb(1, `ATM_REG_STAT, 32'h1);
		wb(1, `ATM_REG_MASK, 32'h0);
		@(posedge i_sys_clk);
		chk({31'h0, irq}, 32'h0);
		n = ev_count;
		smp(0, 12'h100);
		chk({16'h0, ev_code}, 32'hA002);
		smp(0, 12'h800);
		chk(32'(ev_count), 32'(n + 1));
		smp(0, 12'h801);
		chk({16'h0, ev_code}, 32'hA003);
		wb(1, ca(0, `ATM_OFS_CTRL), 32'h01);
		rdchk(ca(0, `ATM_OFS_CTRL), 32'h00);
		wb(1, ca(0, `ATM_OFS_CTRL), 32'h11);
		rdchk(ca(0, `ATM_OFS_CTRL), 32'h10);
		wb(1, ca(0, `ATM_OFS_CTRL), 32'h11);
		rdchk(ca(0, `ATM_OFS_CTRL), 32'h11);
		smp(0, 12'h000);
		rdchk(ca(0, `ATM_OFS_VALUE), vr(2'h3, 12'hFFF));
		wb(1, ca(0, `ATM_OFS_CTRL), 32'h12);
		wb(1, ca(0, `ATM_OFS_DELAY), 32'h2);
		smp(0, 12'h050);
		repeat (30) @(posedge i_sys_clk);
		chk({30'h0, alm_lo}, 32'h1);
		rdchk(`ATM_REG_STAT, 32'h05);
		wb(1, ca(0, `ATM_OFS_DELAY), 32'h32);
		smp(0, 12'h200);
		chk({30'h0, alm_lo}, 32'h0);
		smp(0, 12'h050);
		repeat (100) @(posedge i_sys_clk);
		chk({30'h0, alm_lo}, 32'h0);
		smp(0, 12'h200);
		repeat (150) @(posedge i_sys_clk);
		chk({30'h0, alm_lo}, 32'h0);
		wb(1, ca(0, `ATM_OFS_CTRL), 32'h14);
		wb(1, ca(0, `ATM_OFS_DELAY), 32'h1);
		smp(0, 12'hFFF);
		repeat (20) @(posedge i_sys_clk);
		chk({30'h0, alm_hi}, 32'h1);
		wb(1, ca(1, `ATM_OFS_HIGH), 32'h010);
		wb(1, ca(1, `ATM_OFS_ACT_OK), 32'hB002);
		wb(1, ca(1, `ATM_OFS_ACT_HI), 32'hB003);
		wb(1, ca(1, `ATM_OFS_CTRL), 32'h08);
		n = ev_count;
		smp(1, 12'h020);
		chk(32'(ev_count), 32'(n));
		rdchk(ca(1, `ATM_OFS_VALUE), vr(2'h3, 12'h020));
		wb(1, ca(1, `ATM_OFS_CTRL), 32'h00);
		smp(1, 12'h005);
		chk({15'h0, ev_chan, ev_code}, 32'h1B002);
		smp(1, 12'h030);
		rdchk(`ATM_REG_LAST, 32'h1B003);
		wb(1, ca(1, `ATM_OFS_VALUE), 32'h0);
		rdchk(ca(1, `ATM_OFS_VALUE), vr(2'h3, 12'h030));
		rdchk(8'hFC, 32'h0);
		results;
	end
endmodule
`default_nettype wire
